//--- verilog/hscc_ctrl.sv
// Purpose: Controller end: APB registers, link sequencer, result conversion
// Assumes: APB master that waits on PREADY, sensor on the far end of the link
// Notes:   Makes the link clock by dividing CLOCK
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
module hscc_ctrl
  import hscc_pkg::*;
#(
  parameter int MS_CYC = `HSCC_MS_CYC
)
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  hscc_link_if.ctl         LINK
);
  hscc_host_t q, d;

  // ==========================================================
  // Conversion helpers, results in 0.01 units, ln_rel in 0.001 units
  function automatic int hum_lin(input logic [11:0] r, input logic res);
    logic signed [63:0] x;
    logic signed [63:0] v;
    x = $signed({52'h0, r});
    v = `HSCC_C1 + (res ? `HSCC_C2_8 : `HSCC_C2_12) * x + (res ? `HSCC_C3_8 : `HSCC_C3_12) * x * x;
    v = v / `HSCC_HUM_DIV;
    if (v > `HSCC_RH_SAT)
      v = `HSCC_RH_FULL;
    return int'(v);
  endfunction

  function automatic int ln_rel(input int h);
    int e;
    int fr;
    e = 0;
    for (int i = 0; i < 14; i++)
      if (h[i])
        e = i;
    fr = ((h - (1 << e)) * 1000) >>> e;
    return ((e * 1000 + fr) * `HSCC_LN2_K) / 1000 - `HSCC_LN_FULL;
  endfunction

  function automatic int dew(input int h, input int t);
    int tn;
    int m;
    int g;
    int dn;
    tn = (t >= 0) ? `HSCC_TN_W : `HSCC_TN_I;
    m  = (t >= 0) ? `HSCC_M_W : `HSCC_M_I;
    if (h < 1)
      h = 1;
    if (h > `HSCC_RH_FULL)
      h = `HSCC_RH_FULL;
    dn = tn + t;
    g  = ln_rel(h) + (m * t * 10) / ((dn == 0) ? 1 : dn);
    dn = m * 10 - g;
    return (tn * g) / ((dn == 0) ? 1 : dn);
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic       tick;
    logic       mtick;
    logic       acc;
    logic       wr;
    logic       go;
    logic       hout;
    logic       meas;
    logic       crcb;
    logic [1:0] last;
    logic [3:0] ev;
    int         tc;
    int         lin;
    tc   = 0;
    lin  = 0;
    tick = (q.div == 4'h0);
    mtick = (q.cyc == 15'(MS_CYC - 1));
    acc  = PSEL && PENABLE;
    wr   = acc && q.pready && PWRITE;
    go   = wr && PADDR == `HSCC_A_CTRL && PWDATA[`HSCC_CTRL_GO] && q.st == H_IDLE;
    meas = (q.cmd == `HSCC_CMD_TEMP) || (q.cmd == `HSCC_CMD_HUM);
    hout = (q.byte_n == 2'h0) || (q.cmd == `HSCC_CMD_WRSR);
    last = (q.cmd == `HSCC_CMD_RDSR || q.cmd == `HSCC_CMD_WRSR) ? 2'h1 : (meas ? 2'h2 : 2'h0);
    last = last + {1'b0, q.crc_en && (meas || q.cmd == `HSCC_CMD_RDSR)};
    crcb = q.crc_en && !hout && q.byte_n == last;
    ev   = 4'h0;
    d    = q;
    d.div = tick ? `HSCC_SCK_HALF - 4'h1 : q.div - 4'h1;
    d.cyc = mtick ? 15'h0000 : q.cyc + 15'h0001;
    d.ds  = {q.ds[1:0], LINK.data};
    if (q.ds[1] == q.ds[2])
      d.dl = q.ds[2];
    // Heater watchdog forces a heater-off write
    if (q.sr_w[`HSCC_B_HEAT] && mtick)
    begin
      d.heat_ms = q.heat_ms + 10'h001;
      if (q.heat_ms == 10'(`HSCC_HEAT_MS - 1))
      begin
        d.auto_off = 1'b1;
        d.heat_ms  = 10'h000;
        ev[3]      = 1'b1;
      end
    end
    else if (!q.sr_w[`HSCC_B_HEAT])
      d.heat_ms = 10'h000;
    // Launch of a command from software or the watchdog
    if (go || (q.st == H_IDLE && q.auto_off))
    begin
      d.cmd    = go ? PWDATA[4:0] : `HSCC_CMD_WRSR;
      d.wr     = go ? PWDATA[23:16] & `HSCC_SR_WMASK : q.sr_w & ~8'h04;
      d.crc_en = go ? PWDATA[`HSCC_CTRL_CRC] : 1'b0;
      d.auto_off = go ? q.auto_off : 1'b0;
      d.sh     = {`HSCC_CMD_ADDR, d.cmd};
      d.crc    = 8'h00;
      d.err    = 1'b0;
      d.byte_n = 2'h0;
      d.bit_n  = 4'h0;
      d.ph     = 3'h0;
      d.st     = H_START;
    end
    unique case (q.st)
      H_IDLE: ;
      H_START:
        if (tick)
        begin
          d.ph = q.ph + 3'h1;
          unique case (q.ph)
            3'h0: d.sck = 1'b1;
            3'h1: d.oe = 1'b1;
            3'h2: d.sck = 1'b0;
            3'h3: d.sck = 1'b1;
            3'h4: d.oe = 1'b0;
            default:
            begin
              d.sck = 1'b0;
              d.ph  = 3'h0;
              d.st  = H_BIT;
            end
          endcase
        end
      H_BIT:
        if (tick)
        begin
          d.ph = q.ph + 3'h1;
          if (q.ph == 3'h0)
            d.oe = (q.bit_n < 4'h8) ? hout && !q.sh[7] : !hout && q.byte_n != last;
          else if (q.ph == 3'h1)
          begin
            d.sck = 1'b1;
            if (q.bit_n < 4'h8)
            begin
              d.sh = {q.sh[6:0], hout ? q.sh[7] : q.dl};
              if (!crcb)
                d.crc = hscc_crc_step(q.crc, hout ? q.sh[7] : q.dl);
            end
            else if (hout && q.dl)
              d.err = 1'b1;
          end
          else
          begin
            d.sck = 1'b0;
            d.ph  = 3'h0;
            d.bit_n = q.bit_n + 4'h1;
            if (q.bit_n == 4'h8)
            begin
              d.oe    = 1'b0;
              d.bit_n = 4'h0;
              if (!hout && q.cmd == `HSCC_CMD_RDSR && q.byte_n == 2'h1)
                d.sr_rd = q.sh;
              if (!hout && meas && q.byte_n == 2'h1)
                d.hi = q.sh;
              if (!hout && meas && q.byte_n == 2'h2)
              begin
                if (q.cmd == `HSCC_CMD_HUM)
                  d.hum_raw = {q.hi, q.sh};
                else
                  d.tmp_raw = {q.hi, q.sh};
              end
              if (crcb && q.sh != q.crc)
                ev[2] = 1'b1;
              if (q.err)
              begin
                ev[1] = 1'b1;
                ev[0] = 1'b1;
                d.st  = H_IDLE;
              end
              else if (q.byte_n == 2'h0 && meas)
                d.st = H_READY;
              else if (q.byte_n == 2'h0 && q.cmd == `HSCC_CMD_SRST)
              begin
                d.sr_w = `HSCC_SR_RESET;
                // One spare ms: the sensor starts its own wait a few cycles later
                d.ms   = `HSCC_SRST_MS + 9'd1;
                d.st   = H_HOLD;
              end
              else if (q.byte_n == last)
              begin
                if (q.cmd == `HSCC_CMD_WRSR)
                  d.sr_w = q.wr;
                ev[0] = 1'b1;
                d.st  = H_IDLE;
              end
              else
              begin
                d.byte_n = q.byte_n + 2'h1;
                d.sh     = q.wr;
              end
            end
          end
        end
      H_READY:
        if (tick && !q.dl)
        begin
          d.byte_n = 2'h1;
          d.ph     = 3'h0;
          d.st     = H_BIT;
        end
      H_HOLD:
        if (mtick)
        begin
          d.ms = q.ms - 9'h001;
          if (q.ms == 9'h001)
          begin
            ev[0] = 1'b1;
            d.st  = H_IDLE;
          end
        end
      default: d.st = H_IDLE;
    endcase
    // Conversion from the resolution last written
    tc  = `HSCC_D1 + int'(q.tmp_raw[13:0]) * (q.sr_w[`HSCC_B_RES] ? `HSCC_D2_12 : `HSCC_D2_14);
    lin = hum_lin(q.hum_raw[11:0], q.sr_w[`HSCC_B_RES]);
    d.temp = 16'(tc);
    d.lin  = 16'(lin);
    lin = lin + ((tc - `HSCC_T_REF) * (`HSCC_T1 + int'(q.hum_raw[11:0]) *
          (q.sr_w[`HSCC_B_RES] ? `HSCC_T2_8 : `HSCC_T2_12))) / `HSCC_T_DIV;
    d.comp = 16'(lin);
    d.dew  = 16'(dew(lin, tc));
    // APB slave, one wait state
    d.pready = acc && !q.pready;
    if (acc && !q.pready)
    begin
      d.pslverr = 1'b0;
      unique case (PADDR)
        `HSCC_A_CTRL:  d.prdata = {8'h00, q.wr, 6'h00, q.crc_en, 1'b0, 3'h0, q.cmd};
        `HSCC_A_STAT:  d.prdata = {8'h00, q.sr_w, q.sr_rd, 7'h00, q.st != H_IDLE};
        `HSCC_A_ISTAT: d.prdata = {28'h0000000, q.ist};
        `HSCC_A_IMASK: d.prdata = {28'h0000000, q.imask};
        `HSCC_A_RAW:   d.prdata = {q.tmp_raw, q.hum_raw};
        `HSCC_A_HUM:   d.prdata = {q.comp, q.lin};
        `HSCC_A_TEMP:  d.prdata = {q.dew, q.temp};
        default:
        begin
          d.prdata  = 32'h00000000;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr && PADDR == `HSCC_A_IMASK)
      d.imask = PWDATA[3:0];
    // Sticky events, set wins over write-one-clear
    d.ist = (q.ist & ~((wr && PADDR == `HSCC_A_ISTAT) ? PWDATA[3:0] : 4'h0)) | ev;
    d.irq = |(q.ist & q.imask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      q <= '0;
    else
      q <= d;
  end

  // ==========================================================
  // Outputs
  assign PRDATA      = q.prdata;
  assign PREADY      = q.pready;
  assign PSLVERR     = q.pslverr;
  assign IRQ         = q.irq;
  assign LINK.sck    = q.sck;
  assign LINK.ctl_o  = 1'b0;
  assign LINK.ctl_oe = q.oe;
endmodule

//--- verilog/hscc_map.svh
// Purpose: Constants for the sensor configuration link and its controller
// Assumes: 20 MHz system clock
// Notes:   Included by the package only
`ifndef HSCC_MAP_SVH
`define HSCC_MAP_SVH
// ==========================================================
// Link commands and configuration fields
`define HSCC_CMD_ADDR  3'h0
`define HSCC_CMD_TEMP  5'h03
`define HSCC_CMD_HUM   5'h05
`define HSCC_CMD_RDSR  5'h07
`define HSCC_CMD_WRSR  5'h06
`define HSCC_CMD_SRST  5'h1e
`define HSCC_B_RES     0
`define HSCC_B_RELOAD  1
`define HSCC_B_HEAT    2
`define HSCC_SR_WMASK  8'h07
`define HSCC_SR_RESET  8'h00
`define HSCC_CRC_POLY  8'h31
// ==========================================================
// Timing
`define HSCC_CLK_HZ    20000000
`define HSCC_MS_CYC    (`HSCC_CLK_HZ / 1000)
`define HSCC_T8_MS     9'd20
`define HSCC_T12_MS    9'd80
`define HSCC_T14_MS    9'd320
`define HSCC_RELOAD_MS 9'd10
`define HSCC_SRST_MS   9'd11
`define HSCC_HEAT_MS   1000
`define HSCC_SCK_HALF  4'ha
// ==========================================================
// Controller register offsets
`define HSCC_A_CTRL    8'h00
`define HSCC_A_STAT    8'h04
`define HSCC_A_ISTAT   8'h08
`define HSCC_A_IMASK   8'h0c
`define HSCC_A_RAW     8'h10
`define HSCC_A_HUM     8'h14
`define HSCC_A_TEMP    8'h18
`define HSCC_CTRL_GO   8
`define HSCC_CTRL_CRC  9
// ==========================================================
// Conversion coefficients, humidity scaled 1e10, compensation 1e5, logarithm 1e3, others 0.01 units
`define HSCC_C1        (-64'sd20468000000)
`define HSCC_C2_12     64'sd367000000
`define HSCC_C3_12     (-64'sd15955)
`define HSCC_C2_8      64'sd5872000000
`define HSCC_C3_8      (-64'sd4084500)
`define HSCC_HUM_DIV   64'sd100000000
`define HSCC_RH_SAT    9900
`define HSCC_RH_FULL   10000
`define HSCC_T_REF     2500
`define HSCC_T1        1000
`define HSCC_T2_12     8
`define HSCC_T2_8      128
`define HSCC_T_DIV     100000
`define HSCC_D1        (-4010)
`define HSCC_D2_14     1
`define HSCC_D2_12     4
`define HSCC_TN_W      24312
`define HSCC_M_W       1762
`define HSCC_TN_I      27262
`define HSCC_M_I       2246
`define HSCC_LN2_K     693
`define HSCC_LN_FULL   9210
`endif

//--- verilog/hscc_pkg.sv
// Purpose: Types and shared helpers of the sensor link
// Assumes: hscc_map.svh constants
// Notes:   Both ends import this package
`include "hscc_map.svh"
package hscc_pkg;
  typedef enum logic [2:0] {D_IDLE, D_START, D_CMD, D_WR, D_TX, D_MEAS, D_HOLD} hscc_dst_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_READY, H_HOLD} hscc_hst_t;

  // One serial checksum step
  function automatic logic [7:0] hscc_crc_step(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `HSCC_CRC_POLY : 8'h00);
  endfunction

  typedef struct packed {
    hscc_dst_t   st;
    logic [2:0]  s1, s2, s3, lvl;
    logic [3:0]  bit_n;
    logic [1:0]  byte_n;
    logic        ack;
    logic [7:0]  sh, lo, crc;
    logic [4:0]  cmd;
    logic [2:0]  cfg;
    logic        low;
    logic        oe;
    logic [14:0] cyc;
    logic [8:0]  ms;
  } hscc_dev_t;

  typedef struct packed {
    hscc_hst_t   st;
    logic [2:0]  ph;
    logic [3:0]  bit_n;
    logic [1:0]  byte_n;
    logic [3:0]  div;
    logic [4:0]  cmd;
    logic        crc_en;
    logic [7:0]  wr, sr_w, sr_rd, sh, crc, hi;
    logic [15:0] hum_raw, tmp_raw;
    logic [14:0] cyc;
    logic [8:0]  ms;
    logic [9:0]  heat_ms;
    logic        auto_off, err, sck, oe;
    logic [2:0]  ds;
    logic        dl;
    logic [15:0] lin, comp, temp, dew;
    logic        pready, pslverr;
    logic [31:0] prdata;
    logic [3:0]  ist, imask;
    logic        irq;
  } hscc_host_t;
endpackage

//--- verilog/hscc_link_if.sv
// Purpose: Two-wire link between controller and sensor
// Assumes: Open-drain data, controller-driven clock
// Notes:   Data line level resolved here from both enables
`timescale 1ns/100ps
interface hscc_link_if;
  logic sck;
  logic dev_o;
  logic dev_oe;
  logic ctl_o;
  logic ctl_oe;
  logic data;

  // Pulled-up wire, low while any enabled driver pulls low
  assign data = (dev_oe ? dev_o : 1'b1) & (ctl_oe ? ctl_o : 1'b1);

  modport dev (input sck, input data, output dev_o, output dev_oe);
  modport ctl (output sck, output ctl_o, output ctl_oe, input data);
endinterface

//--- verilog/hscc_sensor.sv
// Purpose: Sensor end: command decode, configuration register, result shift-out
// Assumes: Raw words and supply flag come from the analogue front end
// Notes:   Link pins sampled on CLOCK through three flip-flops
`timescale 1ns/100ps
module hscc_sensor
  import hscc_pkg::*;
#(
  parameter int MS_CYC = `HSCC_MS_CYC
)
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  hscc_link_if.dev         LINK,
  input  wire logic [11:0] HUMIDITY_RAW,
  input  wire logic [13:0] TEMPERATURE_RAW,
  input  wire logic        SUPPLY_LOW,
  output logic             HEATER_ON
);
  hscc_dev_t q, d;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [2:0]  stb;
    logic [2:0]  rise;
    logic [2:0]  fall;
    logic        tick;
    logic        ok;
    logic [15:0] word;
    logic [7:0]  nxt;
    logic [1:0]  last;
    stb  = ~(q.s2 ^ q.s3);
    rise = stb & q.s3 & ~q.lvl;
    fall = stb & ~q.s3 & q.lvl;
    tick = (q.cyc == 15'(MS_CYC - 1));
    ok   = 1'b0;
    word = 16'h0000;
    nxt  = 8'h00;
    last = (q.cmd == `HSCC_CMD_RDSR) ? 2'h1 : 2'h2;
    d    = q;
    d.s1  = {SUPPLY_LOW, LINK.data, LINK.sck};
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (stb & q.s3) | (~stb & q.lvl);
    d.cyc = tick ? 15'h0000 : q.cyc + 15'h0001;
    unique case (q.st)
      D_IDLE:
        if (fall[1] && q.lvl[0])
          d.st = D_START;
      D_START:
        if (rise[1] && q.lvl[0])
        begin
          d.st    = D_CMD;
          d.bit_n = 4'h0;
          d.crc   = 8'h00;
        end
      D_CMD, D_WR:
      begin
        if (rise[0] && q.bit_n < 4'h8)
        begin
          d.sh    = {q.sh[6:0], q.lvl[1]};
          d.crc   = hscc_crc_step(q.crc, q.lvl[1]);
          d.bit_n = q.bit_n + 4'h1;
        end
        // Command needs address 000 and a known code
        if (q.sh[7:5] == `HSCC_CMD_ADDR)
          ok = (q.sh[4:0] == `HSCC_CMD_RDSR) || (q.sh[4:0] == `HSCC_CMD_WRSR) ||
               (q.sh[4:0] == `HSCC_CMD_TEMP) || (q.sh[4:0] == `HSCC_CMD_HUM) ||
               (q.sh[4:0] == `HSCC_CMD_SRST);
        if (fall[0] && q.bit_n == 4'h8)
        begin
          if (!q.oe)
          begin
            d.oe = (q.st == D_WR) || ok;
            if (q.st == D_CMD && !ok)
              d.st = D_IDLE;
          end
          else
          begin
            d.oe    = 1'b0;
            d.bit_n = 4'h0;
            d.st    = D_IDLE;
            if (q.st == D_WR)
              d.cfg = q.sh[2:0] & 3'(`HSCC_SR_WMASK);
            else
            begin
              d.cmd = q.sh[4:0];
              unique case (q.sh[4:0])
                `HSCC_CMD_RDSR:
                begin
                  nxt      = {1'b0, q.low, 3'b000, q.cfg};
                  d.sh     = nxt;
                  d.oe     = ~nxt[7];
                  d.byte_n = 2'h0;
                  d.st     = D_TX;
                end
                `HSCC_CMD_WRSR:
                  d.st = D_WR;
                `HSCC_CMD_SRST:
                begin
                  d.cfg = 3'(`HSCC_SR_RESET);
                  d.ms  = `HSCC_SRST_MS;
                  d.st  = D_HOLD;
                end
                default:
                begin
                  // Measurement time by resolution and reload
                  if (q.sh[4:0] == `HSCC_CMD_HUM)
                    d.ms = q.cfg[`HSCC_B_RES] ? `HSCC_T8_MS : `HSCC_T12_MS;
                  else
                    d.ms = q.cfg[`HSCC_B_RES] ? `HSCC_T12_MS : `HSCC_T14_MS;
                  if (!q.cfg[`HSCC_B_RELOAD])
                    d.ms = d.ms + `HSCC_RELOAD_MS;
                  d.st = D_MEAS;
                end
              endcase
            end
          end
        end
      end
      D_MEAS, D_HOLD:
        if (tick)
        begin
          d.ms = q.ms - 9'h001;
          if (q.ms == 9'h001)
          begin
            d.st = D_IDLE;
            if (q.st == D_MEAS)
            begin
              // Right-justified word, MSB low doubles as data ready
              if (q.cmd == `HSCC_CMD_HUM)
                word = q.cfg[`HSCC_B_RES] ? {8'h00, HUMIDITY_RAW[11:4]} : {4'h0, HUMIDITY_RAW};
              else
                word = q.cfg[`HSCC_B_RES] ? {4'h0, TEMPERATURE_RAW[13:2]} : {2'h0, TEMPERATURE_RAW};
              d.sh     = word[15:8];
              d.lo     = word[7:0];
              d.low    = q.lvl[2];
              d.oe     = ~word[15];
              d.byte_n = 2'h0;
              d.bit_n  = 4'h0;
              d.st     = D_TX;
            end
          end
        end
      D_TX:
      begin
        if (rise[0] && q.bit_n < 4'h8)
        begin
          d.crc   = hscc_crc_step(q.crc, q.sh[7]);
          d.sh    = {q.sh[6:0], 1'b0};
          d.bit_n = q.bit_n + 4'h1;
        end
        else if (rise[0] && q.bit_n == 4'h8)
        begin
          d.ack   = ~q.lvl[1];
          d.bit_n = 4'h9;
        end
        if (fall[0])
        begin
          if (q.bit_n < 4'h8)
            d.oe = ~q.sh[7];
          else if (q.bit_n == 4'h8)
            d.oe = 1'b0;
          else if (q.ack && q.byte_n != last)
          begin
            // Next byte: low result byte, then checksum
            nxt      = (q.byte_n == 2'h0 && q.cmd != `HSCC_CMD_RDSR) ? q.lo : q.crc;
            d.sh     = nxt;
            d.oe     = ~nxt[7];
            d.byte_n = q.byte_n + 2'h1;
            d.bit_n  = 4'h0;
          end
          else
          begin
            d.oe = 1'b0;
            d.st = D_IDLE;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      q <= '0;
    else
      q <= d;
  end

  // ==========================================================
  // Outputs
  assign LINK.dev_o  = 1'b0;
  assign LINK.dev_oe = q.oe;
  assign HEATER_ON   = q.cfg[`HSCC_B_HEAT];
endmodule

//--- tb/hscc_link_monitor.sv
// Purpose: Wire checks on the sensor link
// Assumes: Both ends are design modules
// Notes:   Plain inputs, placed beside the interface
`timescale 1ns/100ps
module hscc_link_monitor
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic sck,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic ctl_o,
  input wire logic ctl_oe,
  input wire logic data
);
  // ==========================================================
  // Link properties
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  a_dev_open_drain: assert property (dev_oe |-> !dev_o)
    else $error("sensor drives data high");
  a_ctl_open_drain: assert property (ctl_oe |-> !ctl_o)
    else $error("controller drives data high");
  a_wire_level: assert property (data == !(dev_oe || ctl_oe))
    else $error("data level differs from drivers");
  a_dev_sck_low: assert property (sck |-> $stable(dev_oe))
    else $error("sensor changed data while clock high");
  a_sck_high_min: assert property ($rose(sck) |-> sck[*8])
    else $error("link clock high too short");
  a_sck_low_min: assert property ($fell(sck) |-> !sck[*8])
    else $error("link clock low too short");
  a_sck_high_max: assert property ($rose(sck) |-> ##[1:20] !sck)
    else $error("link clock high too long");
  a_one_driver: assert property (sck && dev_oe |-> !ctl_oe)
    else $error("both ends drive while clock high");
endmodule

//--- tb/testbench.sv
// Purpose: Controller and sensor joined, driven over APB
// Assumes: Shortened millisecond count
// Notes:   Link bits captured at each clock rise
`timescale 1ns/100ps
module testbench;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        irq, heater_on, supply_low, sck_q, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, sh;
  logic [11:0] hum_raw;
  logic [13:0] tmp_raw;
  int          err_count, cmp_count;

  // ==========================================================
  // Clock, design and checker
  always #25 clock = ~clock;
  hscc_link_if hscc_link_if_inst ();
  hscc_ctrl #(.MS_CYC(20)) hscc_ctrl_inst (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINK(hscc_link_if_inst.ctl));
  hscc_sensor #(.MS_CYC(20)) hscc_sensor_inst (.CLOCK(clock), .ARST_N(arst_n),
    .LINK(hscc_link_if_inst.dev), .HUMIDITY_RAW(hum_raw), .TEMPERATURE_RAW(tmp_raw),
    .SUPPLY_LOW(supply_low), .HEATER_ON(heater_on));
  hscc_link_monitor hscc_link_monitor_inst (.CLOCK(clock), .ARST_N(arst_n),
    .sck(hscc_link_if_inst.sck), .dev_o(hscc_link_if_inst.dev_o), .dev_oe(hscc_link_if_inst.dev_oe),
    .ctl_o(hscc_link_if_inst.ctl_o), .ctl_oe(hscc_link_if_inst.ctl_oe), .data(hscc_link_if_inst.data));

  // Shift in the data level at each link clock rise
  always @(posedge clock)
  begin
    sck_q <= hscc_link_if_inst.sck;
    if (hscc_link_if_inst.sck && !sck_q)
      sh <= {sh[30:0], hscc_link_if_inst.data};
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Scaled result within two counts of the exact value
  task automatic chk_near(input logic [15:0] got, input real exp);
    int e;
    e = $rtoi(exp);
    cmp_count++;
    if ((^got === 1'bx) || ($signed(got) - e > 2) || (e - $signed(got) > 2))
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e[15:0]);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n == 50)
    begin
      err_count++;
      report_and_stop();
    end
  endtask

  // Start a link command, wait for an event, check and clear it
  task automatic run(input logic [31:0] w, input logic [31:0] ist, input logic irq_exp);
    int n;
    apb(1'b1, 8'h00, w | 32'h100);
    for (n = 0; n < 3000; n++)
    begin
      apb(1'b0, 8'h08, 32'h0);
      if (rd !== 32'h0)
        break;
    end
    if (n == 3000)
    begin
      err_count++;
      report_and_stop();
    end
    chk(rd, ist);
    chk({31'h0, irq}, {31'h0, irq_exp});
    apb(1'b1, 8'h08, rd);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    clock = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    supply_low = 1'b0;
    hum_raw = 12'h431;
    tmp_raw = 14'h1770;
    sck_q = 1'b0;
    sh = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], slv}, 32'h1);
    run(32'h00ff0006, 32'h1, 1'b0);
    chk({14'h0, sh[17:0]}, {14'h0, 8'h06, 1'b0, 8'h07, 1'b0});
    chk({31'h0, heater_on}, 32'h1);
    run(32'h00000007, 32'h1, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h00ffbf00, 32'h00070700);
    apb(1'b1, 8'h0c, 32'h1);
    run(32'h00000006, 32'h1, 1'b1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, heater_on}, 32'h0);
    supply_low <= 1'b1;
    run(32'h00000003, 32'h1, 1'b1);
    run(32'h00000205, 32'h1, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h17700431);
    apb(1'b0, 8'h18, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h07c6);
    apb(1'b0, 8'h14, 32'h0);
    chk_near(rd[15:0], 100.0 * (-2.0468 + 0.0367 * 1073 - 1.5955e-6 * 1073 * 1073));
    chk_near(rd[31:16], 3549.53 + (19.9 - 25.0) * (1.0 + 0.008 * 1073));
    run(32'h00000007, 32'h1, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h40);
    hum_raw <= 12'hfff;
    run(32'h00000005, 32'h1, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h2710);
    run(32'h00000001, 32'h3, 1'b1);
    run(32'h00050006, 32'h1, 1'b1);
    chk({31'h0, heater_on}, 32'h1);
    run(32'h0000001e, 32'h1, 1'b1);
    chk({31'h0, heater_on}, 32'h0);
    run(32'h00000007, 32'h1, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk({29'h0, rd[10:8]}, 32'h0);
    report_and_stop();
  end
endmodule
